// ---- rtl/ldd_pkg.sv ----
// Shared constants and types for the display dimming and enable logic
`default_nettype none
package ldd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int LDD_AW     = 5;
    localparam int LDD_DW     = 32;
    localparam int LDD_BYTE_W = 8;
    localparam int LDD_CODE_W = 4;
    localparam int LDD_NBYTES = 3;
    localparam int LDD_NWHITE = 4;
    localparam int LDD_NCOLOUR = 3;
    localparam int LDD_NDROP  = 11;
    localparam int LDD_DUTY_W = 11;

    ////////////////////////////////////////////////////////////////////////
    // Oscillator dividers, in oscillator cycles
    localparam int LDD_COLOUR_DIV   = 240;
    localparam int LDD_SLOT_CYCLES  = 16;
    localparam int LDD_WHITE_DIV    = 1024;
    localparam int LDD_COLOUR_CNT_W = 8;
    localparam int LDD_WHITE_CNT_W  = 10;
    localparam logic [LDD_COLOUR_CNT_W-1:0] LDD_COLOUR_LAST =
        LDD_COLOUR_CNT_W'(LDD_COLOUR_DIV - 1);
    localparam logic [LDD_COLOUR_CNT_W-1:0] LDD_SLOT_LEN =
        LDD_COLOUR_CNT_W'(LDD_SLOT_CYCLES);
    localparam logic [LDD_WHITE_CNT_W-1:0] LDD_WHITE_LAST =
        LDD_WHITE_CNT_W'(LDD_WHITE_DIV - 1);

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [LDD_AW-1:0] LDD_ADDR_HOLD_A = 5'h00;
    localparam logic [LDD_AW-1:0] LDD_ADDR_HOLD_B = 5'h04;
    localparam logic [LDD_AW-1:0] LDD_ADDR_HOLD_C = 5'h08;
    localparam logic [LDD_AW-1:0] LDD_ADDR_STOP   = 5'h0c;
    localparam logic [LDD_AW-1:0] LDD_ADDR_ACTIVE = 5'h10;
    localparam logic [LDD_AW-1:0] LDD_ADDR_STATUS = 5'h14;

    ////////////////////////////////////////////////////////////////////////
    // Byte indices and field positions
    localparam int LDD_BYTE_A      = 0;
    localparam int LDD_BYTE_B      = 1;
    localparam int LDD_BYTE_C      = 2;
    localparam int LDD_FLEX1_BIT   = 0;
    localparam int LDD_FLEX2_BIT   = 1;
    localparam int LDD_TARGET_BIT  = 2;
    localparam int LDD_RED_LO      = 4;
    localparam int LDD_GREEN_LO    = 4;
    localparam int LDD_BLUE_LO     = 0;
    localparam int LDD_MAIN_LO     = 4;
    localparam int LDD_SUB_LO      = 0;
    localparam int LDD_STAT_VALID_LO = 0;
    localparam int LDD_STAT_PIN_BIT  = 3;
    localparam int LDD_STAT_STEP_BIT = 4;
    localparam int LDD_STAT_SHDN_BIT = 5;
    localparam logic [LDD_BYTE_W-1:0] LDD_RST_BYTE = 8'h00;
    localparam logic [LDD_NBYTES-1:0] LDD_ALL_VALID = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // DC subrange codes and white level tables
    typedef logic [1:0] ldd_range_t;
    localparam ldd_range_t LDD_RANGE_OFF = 2'h0;
    localparam ldd_range_t LDD_RANGE_25  = 2'h1;
    localparam ldd_range_t LDD_RANGE_50  = 2'h2;
    localparam ldd_range_t LDD_RANGE_100 = 2'h3;
    localparam logic [LDD_DUTY_W-1:0] LDD_DUTY_TBL [0:15] = '{
        11'h000, 11'h020, 11'h02d, 11'h040, 11'h05b, 11'h080,
        11'h0b5, 11'h100, 11'h16a, 11'h200, 11'h2d4, 11'h400,
        11'h2d4, 11'h400, 11'h2d4, 11'h400};
    localparam ldd_range_t LDD_RANGE_TBL [0:15] = '{
        LDD_RANGE_OFF, LDD_RANGE_25, LDD_RANGE_25, LDD_RANGE_25,
        LDD_RANGE_25, LDD_RANGE_25, LDD_RANGE_25, LDD_RANGE_25,
        LDD_RANGE_25, LDD_RANGE_25, LDD_RANGE_25, LDD_RANGE_25,
        LDD_RANGE_50, LDD_RANGE_50, LDD_RANGE_100, LDD_RANGE_100};

endpackage
`default_nettype wire

// ---- rtl/ldd_colour_pwm.sv ----
// Linear pulse-width generator for the red, green and blue channels
`timescale 1ns/1ps
`default_nettype none
module ldd_colour_pwm (
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    input  wire logic                                       enable,
    input  wire logic [ldd_pkg::LDD_NCOLOUR*ldd_pkg::LDD_CODE_W-1:0] codes,
    output logic      [ldd_pkg::LDD_NCOLOUR-1:0]            chanOn
);
    import ldd_pkg::*;

    typedef struct packed {
        logic [LDD_COLOUR_CNT_W-1:0] cnt;
        logic [LDD_NCOLOUR-1:0]      on;
    } ldd_colour_s;

    ldd_colour_s                st_ff;
    ldd_colour_s                nxt_st;
    logic [LDD_CODE_W-1:0]      slot;
    logic [LDD_NCOLOUR-1:0]     litNext;

    ////////////////////////////////////////////////////////////////////////
    // Slot index: sixteen oscillator cycles per slot
    assign slot = LDD_CODE_W'(st_ff.cnt / LDD_SLOT_LEN);

    // Per channel: lit for as many slots as the code, zero disables
    for (genvar i = 0; i < LDD_NCOLOUR; i++)
    begin : g_chan
        assign litNext[i] = enable
            && (codes[i*LDD_CODE_W +: LDD_CODE_W] != '0)
            && (slot < codes[i*LDD_CODE_W +: LDD_CODE_W]);
    end

    // Period counter wraps every 240 oscillator cycles
    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.cnt == LDD_COLOUR_LAST)
            nxt_st.cnt = '0;
        else
            nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.on = litNext;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign chanOn = st_ff.on;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    colour_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.cnt == LDD_COLOUR_LAST) |=> (st_ff.cnt == '0) ##239
        (st_ff.cnt == LDD_COLOUR_LAST))
        else $error("colour period is not 240 cycles");
    zero_code_a: assert property (@(posedge clk) disable iff (rst)
        (codes[LDD_RED_LO-LDD_RED_LO +: LDD_CODE_W] == '0) |=> !chanOn[0])
        else $error("red channel lit with zero code");
    full_code_a: assert property (@(posedge clk) disable iff (rst)
        (enable && codes[0 +: LDD_CODE_W] == 4'hf) |=> chanOn[0])
        else $error("red channel dark at full code");

endmodule
`default_nettype wire

// ---- rtl/ldd_white_pwm.sv ----
// Subranged pulse-width generator for the white display channels
`timescale 1ns/1ps
`default_nettype none
module ldd_white_pwm (
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    input  wire logic [ldd_pkg::LDD_NWHITE-1:0]             enable,
    input  wire logic [ldd_pkg::LDD_NWHITE*ldd_pkg::LDD_CODE_W-1:0] levels,
    output logic      [ldd_pkg::LDD_NWHITE-1:0]             chanOn,
    output logic      [2*ldd_pkg::LDD_NWHITE-1:0]           chanRange
);
    import ldd_pkg::*;

    typedef struct packed {
        logic [LDD_WHITE_CNT_W-1:0]  cnt;
        logic [LDD_NWHITE-1:0]       on;
        logic [2*LDD_NWHITE-1:0]     range;
    } ldd_white_s;

    ldd_white_s                 st_ff;
    ldd_white_s                 nxt_st;
    logic [LDD_NWHITE-1:0]      litNext;
    logic [2*LDD_NWHITE-1:0]    rangeNext;

    ////////////////////////////////////////////////////////////////////////
    // Per channel: duty and DC subrange looked up from the 4-bit level
    for (genvar i = 0; i < LDD_NWHITE; i++)
    begin : g_chan
        logic [LDD_CODE_W-1:0] lvl;
        assign lvl = levels[i*LDD_CODE_W +: LDD_CODE_W];
        assign litNext[i] = enable[i]
            && ({1'b0, st_ff.cnt} < LDD_DUTY_TBL[lvl]);
        assign rangeNext[2*i +: 2] = enable[i] ? LDD_RANGE_TBL[lvl]
                                               : LDD_RANGE_OFF;
    end

    // Period counter wraps every 1024 oscillator cycles
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.cnt = st_ff.cnt + 1'b1;
        nxt_st.on = litNext;
        nxt_st.range = rangeNext;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign chanOn = st_ff.on;
    assign chanRange = st_ff.range;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    white_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.cnt == LDD_WHITE_LAST) |=> (st_ff.cnt == '0))
        else $error("white period is not 1024 cycles");
    white_off_a: assert property (@(posedge clk) disable iff (rst)
        (!enable[0] || levels[0 +: LDD_CODE_W] == '0)
        |=> (!chanOn[0] && chanRange[1:0] == LDD_RANGE_OFF))
        else $error("white channel lit while off");

endmodule
`default_nettype wire

// ---- rtl/ldd_dimming_enable.sv ----
// Top of the display dimming, enable and step-up request logic
//
// Behaviour
// - Each flexible white channel is assigned to MAIN or SUB independently.
// - An assigned flexible channel uses that display's subrange and duty.
// - Dropout on any active channel switches supply to step-up mode.
// - A colour channel with code zero is disabled and ignores dropout.
// - Colour duty equals code over fifteen, linear in equal steps.
// - Red, green and blue each hold a 4-bit unsigned code.
// - Colour period is the oscillator divided by 240.
// - Target bit 0 makes the enable pin gate RGB, 1 gates SUB.
// - SUB targeted: pin high lights SUB at its level, low turns off.
// - RGB targeted: pin high lights colours, low turns all three off.
// - Nothing lit after pin gating means the whole device shuts down.
// - The enable pin never affects the display it does not target.
// - Data bytes wait in holding latch, copied on valid STOP.
// - White period is the oscillator divided by 1024.
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ldd_dimming_enable (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic [ldd_pkg::LDD_AW-1:0]         avs_address,
    input  wire logic                               avs_read,
    input  wire logic                               avs_write,
    input  wire logic [ldd_pkg::LDD_DW-1:0]         avs_writedata,
    input  wire logic [3:0]                         avs_byteenable,
    output logic      [ldd_pkg::LDD_DW-1:0]         avs_readdata,
    output logic                                    avs_waitrequest,
    input  wire logic                               extDisplayEnablePin,
    input  wire logic [ldd_pkg::LDD_NWHITE*2-1:0]   whiteDropout,
    input  wire logic [ldd_pkg::LDD_NCOLOUR-1:0]    colourDropout,
    output logic                                    redOn,
    output logic                                    greenOn,
    output logic                                    blueOn,
    output logic                                    mainOn,
    output logic                                    subOn,
    output logic                                    flexWhiteOneOn,
    output logic                                    flexWhiteTwoOn,
    output ldd_pkg::ldd_range_t                     mainRange,
    output ldd_pkg::ldd_range_t                     subRange,
    output ldd_pkg::ldd_range_t                     flexOneRange,
    output ldd_pkg::ldd_range_t                     flexTwoRange,
    output logic                                    stepUpMode,
    output logic                                    shutdown
);
    import ldd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [LDD_NBYTES-1:0][LDD_BYTE_W-1:0] hold;
        logic [LDD_NBYTES-1:0][LDD_BYTE_W-1:0] act;
        logic [LDD_NBYTES-1:0]                 holdValid;
        logic                                  ackd;
        logic [LDD_DW-1:0]                     rdData;
        logic                                  enMeta;
        logic                                  enSync;
        logic [LDD_NDROP-1:0]                  dropMeta;
        logic [LDD_NDROP-1:0]                  dropSync;
        logic                                  stepUp;
        logic                                  shdn;
    } ldd_main_s;

    ldd_main_s                      st_ff;
    ldd_main_s                      nxt_st;
    logic                           busReq;
    logic                           firstCycle;
    logic                           accept;
    logic                           commit;
    logic                           targetSub;
    logic                           rgbGate;
    logic                           subGate;
    logic [LDD_CODE_W-1:0]          redCode;
    logic [LDD_CODE_W-1:0]          greenCode;
    logic [LDD_CODE_W-1:0]          blueCode;
    logic [LDD_CODE_W-1:0]          mainLvl;
    logic [LDD_CODE_W-1:0]          subLvl;
    logic [LDD_CODE_W-1:0]          flexOneLvl;
    logic [LDD_CODE_W-1:0]          flexTwoLvl;
    logic                           flexOneEn;
    logic                           flexTwoEn;
    logic [LDD_NWHITE-1:0]          whiteEn;
    logic [LDD_NDROP-1:0]           activeMask;
    logic                           nothingLit;
    logic [LDD_NCOLOUR-1:0]         colourOn;
    logic [LDD_NWHITE-1:0]          whiteOn;
    logic [2*LDD_NWHITE-1:0]        whiteRange;

    ////////////////////////////////////////////////////////////////////////
    // Avalon handshake: one wait cycle, then the request is taken

    assign busReq     = avs_read | avs_write;
    assign firstCycle = busReq & !st_ff.ackd;
    assign accept     = avs_write & st_ff.ackd;
    assign commit     = accept && (avs_address == LDD_ADDR_STOP)
                        && (st_ff.holdValid == LDD_ALL_VALID);
    assign avs_waitrequest = firstCycle;
    assign avs_readdata    = st_ff.rdData;

    ////////////////////////////////////////////////////////////////////////
    // Field decode of the active command latch

    assign targetSub  = st_ff.act[LDD_BYTE_A][LDD_TARGET_BIT];
    assign redCode    = st_ff.act[LDD_BYTE_A][LDD_RED_LO +: LDD_CODE_W];
    assign greenCode  = st_ff.act[LDD_BYTE_B][LDD_GREEN_LO +: LDD_CODE_W];
    assign blueCode   = st_ff.act[LDD_BYTE_B][LDD_BLUE_LO +: LDD_CODE_W];
    assign mainLvl    = st_ff.act[LDD_BYTE_C][LDD_MAIN_LO +: LDD_CODE_W];
    assign subLvl     = st_ff.act[LDD_BYTE_C][LDD_SUB_LO +: LDD_CODE_W];

    // Enable pin gates only the targeted display
    assign rgbGate = targetSub ? 1'b1 : st_ff.enSync;
    assign subGate = targetSub ? st_ff.enSync : 1'b1;

    // Flexible channels pick the level and gate of their display
    assign flexOneLvl = st_ff.act[LDD_BYTE_A][LDD_FLEX1_BIT] ? subLvl
                        : mainLvl;
    assign flexTwoLvl = st_ff.act[LDD_BYTE_A][LDD_FLEX2_BIT] ? subLvl
                        : mainLvl;
    assign flexOneEn  = st_ff.act[LDD_BYTE_A][LDD_FLEX1_BIT] ? subGate
                                                            : 1'b1;
    assign flexTwoEn  = st_ff.act[LDD_BYTE_A][LDD_FLEX2_BIT] ? subGate
                                                            : 1'b1;
    assign whiteEn = {flexTwoEn, flexOneEn, subGate, 1'b1};

    // Channels that are lit and may request step-up
    assign activeMask = {
        {(blueCode != '0) & rgbGate},
        {(greenCode != '0) & rgbGate},
        {(redCode != '0) & rgbGate},
        {(flexTwoLvl != '0) & flexTwoEn},
        {(flexOneLvl != '0) & flexOneEn},
        {2{(subLvl != '0) & subGate}},
        {4{mainLvl != '0}}};
    assign nothingLit = (activeMask == '0);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        nxt_st = st_ff;
        // Pin and dropout synchronisers
        nxt_st.enMeta   = extDisplayEnablePin;
        nxt_st.enSync   = st_ff.enMeta;
        nxt_st.dropMeta = {colourDropout, whiteDropout};
        nxt_st.dropSync = st_ff.dropMeta;
        // Bus answer in the wait cycle
        nxt_st.ackd = firstCycle;
        if (firstCycle && avs_read)
        begin
            nxt_st.rdData = '0;
            unique case (avs_address)
                LDD_ADDR_HOLD_A: nxt_st.rdData[LDD_BYTE_W-1:0] =
                    st_ff.hold[LDD_BYTE_A];
                LDD_ADDR_HOLD_B: nxt_st.rdData[LDD_BYTE_W-1:0] =
                    st_ff.hold[LDD_BYTE_B];
                LDD_ADDR_HOLD_C: nxt_st.rdData[LDD_BYTE_W-1:0] =
                    st_ff.hold[LDD_BYTE_C];
                LDD_ADDR_ACTIVE: nxt_st.rdData[LDD_NBYTES*LDD_BYTE_W-1:0] =
                    st_ff.act;
                LDD_ADDR_STATUS:
                begin
                    nxt_st.rdData[LDD_STAT_VALID_LO +: LDD_NBYTES] =
                        st_ff.holdValid;
                    nxt_st.rdData[LDD_STAT_PIN_BIT]  = st_ff.enSync;
                    nxt_st.rdData[LDD_STAT_STEP_BIT] = st_ff.stepUp;
                    nxt_st.rdData[LDD_STAT_SHDN_BIT] = st_ff.shdn;
                end
                default: nxt_st.rdData = '0;
            endcase
        end
        // Data bytes land in the holding latch only
        if (accept && avs_byteenable[0])
        begin
            unique case (avs_address)
                LDD_ADDR_HOLD_A:
                begin
                    nxt_st.hold[LDD_BYTE_A] = avs_writedata[LDD_BYTE_W-1:0];
                    nxt_st.holdValid[LDD_BYTE_A] = 1'b1;
                end
                LDD_ADDR_HOLD_B:
                begin
                    nxt_st.hold[LDD_BYTE_B] = avs_writedata[LDD_BYTE_W-1:0];
                    nxt_st.holdValid[LDD_BYTE_B] = 1'b1;
                end
                LDD_ADDR_HOLD_C:
                begin
                    nxt_st.hold[LDD_BYTE_C] = avs_writedata[LDD_BYTE_W-1:0];
                    nxt_st.holdValid[LDD_BYTE_C] = 1'b1;
                end
                default: nxt_st.holdValid = st_ff.holdValid;
            endcase
        end
        // STOP copies a complete set into the command latch
        if (commit)
        begin
            nxt_st.act = st_ff.hold;
            nxt_st.holdValid = '0;
        end
        // Direct-connect after shutdown, step-up once any active drops out
        if (nothingLit)
            nxt_st.stepUp = 1'b0;
        else if ((st_ff.dropSync & activeMask) != '0)
            nxt_st.stepUp = 1'b1;
        nxt_st.shdn = nothingLit;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
            st_ff.act <= {LDD_NBYTES{LDD_RST_BYTE}};
            st_ff.hold <= {LDD_NBYTES{LDD_RST_BYTE}};
        end
        else
            st_ff <= nxt_st;
    end

    assign stepUpMode = st_ff.stepUp;
    assign shutdown   = st_ff.shdn;

    ////////////////////////////////////////////////////////////////////////
    // Pulse-width generators

    ldd_colour_pwm u_colour (
        .clk    (clk),
        .rst    (rst),
        .enable (rgbGate),
        .codes  ({blueCode, greenCode, redCode}),
        .chanOn (colourOn)
    );

    ldd_white_pwm u_white (
        .clk       (clk),
        .rst       (rst),
        .enable    (whiteEn),
        .levels    ({flexTwoLvl, flexOneLvl, subLvl, mainLvl}),
        .chanOn    (whiteOn),
        .chanRange (whiteRange)
    );

    assign redOn          = colourOn[0];
    assign greenOn        = colourOn[1];
    assign blueOn         = colourOn[2];
    assign mainOn         = whiteOn[0];
    assign subOn          = whiteOn[1];
    assign flexWhiteOneOn = whiteOn[2];
    assign flexWhiteTwoOn = whiteOn[3];
    assign mainRange      = whiteRange[1:0];
    assign subRange       = whiteRange[3:2];
    assign flexOneRange   = whiteRange[5:4];
    assign flexTwoRange   = whiteRange[7:6];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    commit_copy_a: assert property (
        commit |=> (st_ff.act == $past(st_ff.hold)) && (st_ff.holdValid == '0))
        else $error("STOP did not copy the holding latch");
    latch_only_stop_a: assert property (
        (st_ff.act != $past(st_ff.act)) |-> $past(commit))
        else $error("command latch changed without STOP");
    step_up_a: assert property (
        ((st_ff.dropSync & activeMask) != '0) |=> st_ff.stepUp)
        else $error("active dropout did not request step-up");
    shutdown_a: assert property (
        nothingLit |=> shutdown && !stepUpMode && !mainOn && !redOn)
        else $error("device not shut down with nothing lit");
    rgb_gate_a: assert property (
        (!targetSub && !st_ff.enSync)
        |=> (!redOn && !greenOn && !blueOn))
        else $error("RGB lit with enable pin low");
    sub_gate_a: assert property (
        (targetSub && !st_ff.enSync)
        |=> (!subOn && subRange == LDD_RANGE_OFF))
        else $error("SUB lit with enable pin low");
    pin_ignored_a: assert property (
        (targetSub && redCode == 4'hf) |=> redOn)
        else $error("enable pin gated an untargeted display");
    flex_follow_a: assert property (
        ($past(st_ff.act) == st_ff.act && $past(st_ff.enSync) == st_ff.enSync)
        |-> (flexOneRange == (st_ff.act[LDD_BYTE_A][LDD_FLEX1_BIT] ? subRange
                                                                  : mainRange))
        && (flexWhiteOneOn == (st_ff.act[LDD_BYTE_A][LDD_FLEX1_BIT] ? subOn
                                                                   : mainOn)))
        else $error("flexible channel does not follow its display");

endmodule
`default_nettype wire

// ---- dv/ldd_host_model.sv ----
// Register bus master standing in for the serial host
`timescale 1ns/1ps
`default_nettype none
module ldd_host_model (
    input  wire logic [ldd_pkg::LDD_DW-1:0] readdata,
    input  wire logic                       waitrequest,
    input  wire logic                       clk,
    output logic      [ldd_pkg::LDD_AW-1:0] address,
    output logic                            read,
    output logic                            write,
    output logic      [ldd_pkg::LDD_DW-1:0] writedata,
    output logic      [3:0]                 byteenable
);
    import ldd_pkg::*;
    // Idle bus at time zero
    initial
    begin
        address = 5'h0;
        read = 1'h0;
        write = 1'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
    end
    // One access, held until waitrequest is sampled low at a rising edge
    task automatic acc(input logic [4:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= d;
        do
            @(posedge clk);
        while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ---- dv/ldd_dimming_enable_test.sv ----
// Self-checking bench for the dimming and enable logic
`timescale 1ns/1ps
`default_nettype none
module ldd_dimming_enable_test;
    import ldd_pkg::*;
    logic clk, rst, pin, rdReq, wrReq, waitReq, redOn, greenOn, blueOn;
    logic mainOn, subOn, f1On, f2On, stepUpMode, shutdown;
    logic [4:0] adr;
    logic [3:0] be;
    logic [7:0] whiteDrop;
    logic [2:0] colDrop;
    logic [31:0] wdata, rdata, q;
    ldd_range_t mainR, subR, f1R, f2R;
    int badCount = 0, cmpCount = 0, r, b;
    ldd_host_model i_host (.readdata(rdata), .waitrequest(waitReq),
        .clk(clk), .address(adr), .read(rdReq), .write(wrReq),
        .writedata(wdata), .byteenable(be));
    ldd_dimming_enable i_ldd_dimming_enable (.clk(clk), .rst(rst),
        .avs_address(adr), .avs_read(rdReq), .avs_write(wrReq),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .extDisplayEnablePin(pin),
        .whiteDropout(whiteDrop), .colourDropout(colDrop), .redOn(redOn),
        .greenOn(greenOn), .blueOn(blueOn), .mainOn(mainOn), .subOn(subOn),
        .flexWhiteOneOn(f1On), .flexWhiteTwoOn(f2On), .mainRange(mainR),
        .subRange(subR), .flexOneRange(f1R), .flexTwoRange(f2R),
        .stepUpMode(stepUpMode), .shutdown(shutdown));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
            badCount++;
        if (seen !== exp)
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    endtask
    task automatic stop_test;
        if (badCount == 0 && cmpCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Lit cycles of red and blue over one colour period
    task automatic duty;
        r = 0;
        b = 0;
        repeat (240)
        begin
            @(negedge clk);
            r += redOn;
            b += blueOn;
        end
        @(posedge clk);
    endtask
    // Three hold bytes, a STOP, then settling
    task automatic cfg(input logic [7:0] x, input logic [7:0] y,
                       input logic [7:0] z);
        i_host.acc(LDD_ADDR_HOLD_A, 1'h1, {24'h0, x}, q);
        i_host.acc(LDD_ADDR_HOLD_B, 1'h1, {24'h0, y}, q);
        i_host.acc(LDD_ADDR_HOLD_C, 1'h1, {24'h0, z}, q);
        i_host.acc(LDD_ADDR_STOP, 1'h1, 32'h0, q);
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // Watchdog
    initial
    begin
        #2000000;
        badCount++;
        stop_test();
    end
    // Scenarios
    initial
    begin
        rst = 1'h1;
        pin = 1'h0;
        whiteDrop = 8'h0;
        colDrop = 3'h0;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        cfg(8'hf0, 8'h01, 8'h00);
        chk(shutdown, 32'h1);
        pin <= 1'h1;
        repeat (4) @(posedge clk);
        duty();
        chk(r, 32'hf0);
        chk(b, 32'h10);
        chk(greenOn, 32'h0);
        colDrop <= 3'h2;
        repeat (4) @(posedge clk);
        chk(stepUpMode, 32'h0);
        colDrop <= 3'h1;
        repeat (4) @(posedge clk);
        chk(stepUpMode, 32'h1);
        colDrop <= 3'h0;
        cfg(8'h55, 8'h00, 8'h03);
        duty();
        chk(r, 32'h50);
        chk(subR, LDD_RANGE_25);
        chk(f1R, LDD_RANGE_25);
        chk(f2R, LDD_RANGE_OFF);
        chk(mainR, LDD_RANGE_OFF);
        chk(f2On, 32'h0);
        pin <= 1'h0;
        repeat (4) @(posedge clk);
        duty();
        chk(subR, LDD_RANGE_OFF);
        chk(subOn, 32'h0);
        chk(f1On, 32'h0);
        chk(mainOn, 32'h0);
        chk(r, 32'h50);
        chk(shutdown, 32'h0);
        i_host.acc(LDD_ADDR_HOLD_A, 1'h1, 32'h0, q);
        i_host.acc(LDD_ADDR_STOP, 1'h1, 32'h0, q);
        i_host.acc(LDD_ADDR_ACTIVE, 1'h0, 32'h0, q);
        chk(q, 32'h030055);
        i_host.acc(LDD_ADDR_STATUS, 1'h0, 32'h0, q);
        chk(q, 32'h11);
        stop_test();
    end
endmodule
`default_nettype wire
